// ### logic/tfc_clk_mon.v
// transmit clock source selection and loss-of-transition watch for one port
// assumes both clocks are slow pins sampled by the 100 MHz system clock
`timescale 1ns/100ps
`default_nettype none
`include "tfc_defines.vh"
module tfc_clk_mon #(
	parameter CHAN_CYCLES = `TFC_CHAN_CYCLES
) (
	input wire i_clk,
	input wire i_arst_n,
	input wire i_line_tx_clock_pin,
	input wire i_recovered_rx_clock,
	input wire i_tx_clock_invert,
	input wire [1:0] i_tx_clk_src_sel,
	output reg o_use_rx_clock,
	output reg o_tx_clock
);
	reg [1:0] line_sync;
	reg [1:0] rx_sync;
	reg line_last;
	reg [15:0] idle_cnt;
	reg failed;
	wire line_edge;
	wire next_use_rx;

	assign line_edge = line_sync[1] ^ line_last;
	// reserved code 10 selects the pin as 00 does, with no fallback to the receive clock when the pin stops
	assign next_use_rx = (i_tx_clk_src_sel == 2'b11) ||
		((i_tx_clk_src_sel == 2'b01) && failed);

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			line_sync <= 2'b00;
			rx_sync <= 2'b00;
			line_last <= 1'b0;
			idle_cnt <= 16'h0000;
			failed <= 1'b0;
			o_use_rx_clock <= 1'b0;
			o_tx_clock <= 1'b0;
		end else begin
			line_sync <= {line_sync[0], i_line_tx_clock_pin};
			rx_sync <= {rx_sync[0], i_recovered_rx_clock};
			line_last <= line_sync[1];
			if (line_edge) begin
				idle_cnt <= 16'h0000;
				failed <= 1'b0;
			end else if (idle_cnt >= CHAN_CYCLES[15:0] - 16'h0001) begin
				failed <= 1'b1;
			end else begin
				idle_cnt <= idle_cnt + 16'h0001;
			end
			o_use_rx_clock <= next_use_rx;
			o_tx_clock <= next_use_rx ? rx_sync[1] : (line_sync[1] ^ i_tx_clock_invert);
		end
	end
endmodule // tfc_clk_mon
`default_nettype wire

// ### logic/tfc_defines.vh
// constants for the per-port transmit framer control register set
// assumes word-wide APB access; printed offsets are word indexes
// Summary of operation
// - alarm type 0 selects T1 alarm: D4 zero bit 2, ESF 00FF on link.
// - alarm type 1 selects J1 alarm: D4 S-bit frame 12, ESF all ones.
// - alarm type picks only the pattern; nothing sent without alarm enable.
// - bit-7 suppression enable stuffs qualifying zero channels; off means no stuffing.
// - E1 control 2 bits 7,6,5 enable auto E-bits, auto AIS, auto alarm.
// - clock source 00 pin, 01 fallback after one channel idle, 11 receive clock.
// - reference 0 uses line counters aligned to sync input, free-run when output.
// - reference 1 uses system counters passed forward; needs slip-free elastic store.
// - T1 frame mode bit 0 selects ESF, 1 selects D4.
// - rising insert-violation bit arms one violation at next three ones.
// - control 3 bit 0 is loop code in T1, CRC-4 recalculation in E1.
// - I/O bits 7,6,5 invert clock pin, sync pin, system sync input.
// - sync mode bits select frame pulses at 0, multiframe pulses at 1.
// - sync direction 0 makes sync pin input, 1 output.
// - T1 double-wide sync pulse only with output pin in frame mode.
// - channel format 0 is 64 kbit/s all bits, 1 is 56 kbit/s.
// - gapped clock enable makes channel clock output a gapped bit clock.
// - in rate conversion, slip when separation at most 9 or 2 bytes.
// - rising align restores half-frame separation, no action if already enough.
// - rising store reset moves read pointer; slips at once if in zone.
// - elastic store bypassed unless enabled; min-delay picks 32-bit depth.
// - milliwatt select 0 inserts u-law code, 1 inserts A-law code.
// - mode bit selects T1 at 0, E1 at 1, steering bit meanings.
// - remote alarm enable sends selected alarm when set, none when clear.
// - global bit-7 stuffing, with suppression enable set, stuffs every all-zero channel.
`ifndef TFC_DEFINES_VH
`define TFC_DEFINES_VH

`define TFC_IDX_MODE 12'h180
`define TFC_IDX_CTRL1 12'h181
`define TFC_IDX_CTRL2 12'h182
`define TFC_IDX_CTRL3 12'h183
`define TFC_IDX_IO 12'h184
`define TFC_IDX_ESTORE 12'h185
`define TFC_IDX_CTRL4 12'h186
`define TFC_PORT_STRIDE 12'h200
`define TFC_NREGS 7
`define TFC_RESET_VAL 8'h00

// writable bits per register, indexed as offset from the mode register
`define TFC_MASK_MODE 8'hC3
`define TFC_MASK_CTRL1 8'hFF
`define TFC_MASK_CTRL2 8'hFF
`define TFC_MASK_CTRL3 8'h3F
`define TFC_MASK_IO 8'hFF
`define TFC_MASK_ESTORE 8'hDF
`define TFC_MASK_CTRL4 8'hFF

// field positions
`define TFC_B_STD 0
`define TFC_B_RAI_EN 0
`define TFC_B_GB7 3
`define TFC_B_B7ZS 0
`define TFC_B_RAI_TYPE 2
`define TFC_B_ARA 5
`define TFC_B_AUTO_AIS_GEN_EN 6
`define TFC_B_AUTO_EBIT_EN 7
`define TFC_B_BIT0 0
`define TFC_B_INSERT_VIOLATION_TRIGGER 1
`define TFC_B_TFM 2
`define TFC_B_MULTIFRAME_REF_SEL 3
`define TFC_B_CSS_LO 4
`define TFC_B_TSM 0
`define TFC_B_SYNC_DOUBLE_WIDE_EN 1
`define TFC_B_TX_SYNC_DIRECTION 2
`define TFC_B_SYSTEM_SYNC_FRAME_MODE 3
`define TFC_B_SCLKM 4
`define TFC_B_SSINV 5
`define TFC_B_SINV 6
`define TFC_B_CINV 7
`define TFC_B_ESE 0
`define TFC_B_MDM 1
`define TFC_B_ESR 2
`define TFC_B_ALGN 3
`define TFC_B_SZS 4
`define TFC_B_GCLK 6
`define TFC_B_FMT 7
`define TFC_B_LAW 7

// timing and elastic store figures
`define TFC_CLK_PERIOD_NS 10
`define TFC_CHAN_TIME_NS 5181
`define TFC_CHAN_CYCLES (`TFC_CHAN_TIME_NS / `TFC_CLK_PERIOD_NS)
`define TFC_SLIP_ZONE_WIDE 7'd9
`define TFC_SLIP_ZONE_NARROW 7'd2
`define TFC_HALF_FRAME_T1 7'd12
`define TFC_HALF_FRAME_E1 7'd16
`define TFC_ONES_RUN 2'd3

`endif

// ### logic/tfc_regs.v
// per-port transmit control registers on APB with decoded control outputs
// assumes single-beat 32-bit APB word accesses; formatter signals share i_clk
`timescale 1ns/100ps
`default_nettype none
`include "tfc_defines.vh"
module tfc_regs #(
	parameter NPORTS = 4,
	parameter CHAN_CYCLES = `TFC_CHAN_CYCLES
) (
	input wire i_clk,
	input wire i_arst_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [15:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	input wire [NPORTS-1:0] i_line_tx_clock_pin,
	input wire [NPORTS-1:0] i_recovered_rx_clock,
	input wire [NPORTS-1:0] i_line_tx_sync_pin,
	input wire [NPORTS-1:0] i_system_tx_sync_pin,
	input wire [NPORTS-1:0] i_tx_sync_gen,
	input wire [NPORTS-1:0] i_tx_bit_valid,
	input wire [NPORTS-1:0] i_tx_bit,
	input wire [NPORTS-1:0] i_rate_convert,
	input wire [7*NPORTS-1:0] i_estore_sep,
	output wire [NPORTS-1:0] o_tx_clock,
	output wire [NPORTS-1:0] o_use_rx_clock,
	output reg [NPORTS-1:0] o_line_tx_sync_pin,
	output reg [NPORTS-1:0] o_line_tx_sync_oe_n,
	output reg [NPORTS-1:0] o_tx_sync_in,
	output reg [NPORTS-1:0] o_system_sync_in,
	output reg [NPORTS-1:0] o_e1_mode,
	output reg [NPORTS-1:0] o_rai_send,
	output reg [NPORTS-1:0] o_rai_j1,
	output reg [NPORTS-1:0] o_d4_framing,
	output reg [NPORTS-1:0] o_b7_stuff_all,
	output reg [NPORTS-1:0] o_b7_stuff_sel,
	output reg [NPORTS-1:0] o_auto_ebit,
	output reg [NPORTS-1:0] o_auto_ais,
	output reg [NPORTS-1:0] o_auto_rai,
	output reg [NPORTS-1:0] o_mf_ref_system,
	output reg [NPORTS-1:0] o_loop_code_en,
	output reg [NPORTS-1:0] o_crc4_recalc,
	output reg [NPORTS-1:0] o_sysclk_fast,
	output reg [NPORTS-1:0] o_system_sync_mf,
	output reg [NPORTS-1:0] o_tx_sync_mf,
	output reg [NPORTS-1:0] o_sync_double_wide,
	output reg [NPORTS-1:0] o_rate_56k,
	output reg [NPORTS-1:0] o_gapped_clk,
	output reg [NPORTS-1:0] o_estore_en,
	output reg [NPORTS-1:0] o_estore_min_delay,
	output reg [NPORTS-1:0] o_milliwatt_alaw,
	output reg [NPORTS-1:0] o_bpv_armed,
	output reg [NPORTS-1:0] o_bpv_insert,
	output reg [NPORTS-1:0] o_estore_align,
	output reg [NPORTS-1:0] o_estore_reset,
	output reg [NPORTS-1:0] o_estore_slip
);
	reg [7:0] regs [0:`TFC_NREGS*NPORTS-1];
	wire [5:0] dec;
	wire hit;
	wire [1:0] sel_port;
	wire [2:0] sel_reg;
	wire wr_en;
	integer k;

	// {hit, port, register}; any unaligned, unmapped or absent-port word misses
	function [5:0] decode;
		input [15:0] addr;
		reg [13:0] word;
		reg [13:0] off;
		begin
			word = addr[15:2];
			off = word - {2'b00, `TFC_IDX_MODE};
			decode = 6'h00;
			if (addr[1:0] == 2'b00 && word >= {2'b00, `TFC_IDX_MODE} &&
				off[13:11] == 3'b000 && off[8:0] < `TFC_NREGS &&
				{1'b0, off[10:9]} < NPORTS) begin
				decode = {1'b1, off[10:9], off[2:0]};
			end
		end
	endfunction

	function [7:0] wmask;
		input [2:0] r;
		begin
			case (r)
				3'd0: wmask = `TFC_MASK_MODE;
				3'd1: wmask = `TFC_MASK_CTRL1;
				3'd2: wmask = `TFC_MASK_CTRL2;
				3'd3: wmask = `TFC_MASK_CTRL3;
				3'd4: wmask = `TFC_MASK_IO;
				3'd5: wmask = `TFC_MASK_ESTORE;
				3'd6: wmask = `TFC_MASK_CTRL4;
				default: wmask = 8'h00;
			endcase
		end
	endfunction

	assign dec = decode(i_paddr);
	assign hit = dec[5];
	assign sel_port = dec[4:3];
	assign sel_reg = dec[2:0];
	assign wr_en = i_psel && i_penable && i_pwrite && hit;
	// zero wait states: every access completes in its first access cycle
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;
	assign o_prdata = hit ? {24'h00_0000, regs[sel_port * `TFC_NREGS + sel_reg]} : 32'h0000_0000;

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (k = 0; k < `TFC_NREGS*NPORTS; k = k + 1) begin
				regs[k] <= `TFC_RESET_VAL;
			end
		end else if (wr_en) begin
			regs[sel_port * `TFC_NREGS + sel_reg] <= i_pwdata[7:0] & wmask(sel_reg);
		end
	end

	genvar p;
	generate
		for (p = 0; p < NPORTS; p = p + 1) begin : g_port
			wire [7:0] r_mode;
			wire [7:0] r_c1;
			wire [7:0] r_c2;
			wire [7:0] r_c3;
			wire [7:0] r_io;
			wire [7:0] r_es;
			wire [7:0] r_c4;
			wire e1;
			wire wr_here;
			wire bpv_rise;
			wire algn_rise;
			wire esr_rise;
			wire [6:0] sep;
			wire [6:0] zone;
			wire [6:0] half;
			wire bpv_fire;
			reg [1:0] sync_line;
			reg [1:0] sync_sys;
			reg [1:0] ones_run;
			reg reset_seen;

			assign r_mode = regs[p*`TFC_NREGS + 0];
			assign r_c1 = regs[p*`TFC_NREGS + 1];
			assign r_c2 = regs[p*`TFC_NREGS + 2];
			assign r_c3 = regs[p*`TFC_NREGS + 3];
			assign r_io = regs[p*`TFC_NREGS + 4];
			assign r_es = regs[p*`TFC_NREGS + 5];
			assign r_c4 = regs[p*`TFC_NREGS + 6];
			assign e1 = r_mode[`TFC_B_STD];
			assign wr_here = wr_en && ({1'b0, sel_port} == p);
			// commands act on a written 0-to-1 change only; holding the bit does nothing
			assign bpv_rise = wr_here && sel_reg == 3'd3 &&
				i_pwdata[`TFC_B_INSERT_VIOLATION_TRIGGER] && !r_c3[`TFC_B_INSERT_VIOLATION_TRIGGER];
			assign algn_rise = wr_here && sel_reg == 3'd5 &&
				i_pwdata[`TFC_B_ALGN] && !r_es[`TFC_B_ALGN];
			assign esr_rise = wr_here && sel_reg == 3'd5 &&
				i_pwdata[`TFC_B_ESR] && !r_es[`TFC_B_ESR];
			assign sep = i_estore_sep[7*p +: 7];
			assign zone = r_es[`TFC_B_SZS] ? `TFC_SLIP_ZONE_NARROW : `TFC_SLIP_ZONE_WIDE;
			assign half = e1 ? `TFC_HALF_FRAME_E1 : `TFC_HALF_FRAME_T1;
			assign bpv_fire = o_bpv_armed[p] && i_tx_bit_valid[p] && i_tx_bit[p] &&
				(ones_run >= `TFC_ONES_RUN - 2'd1);

			tfc_clk_mon #(
				.CHAN_CYCLES(CHAN_CYCLES)
			) u_clk_mon (
				.i_clk(i_clk),
				.i_arst_n(i_arst_n),
				.i_line_tx_clock_pin(i_line_tx_clock_pin[p]),
				.i_recovered_rx_clock(i_recovered_rx_clock[p]),
				.i_tx_clock_invert(r_io[`TFC_B_CINV]),
				.i_tx_clk_src_sel(r_c3[`TFC_B_CSS_LO +: 2]),
				.o_use_rx_clock(o_use_rx_clock[p]),
				.o_tx_clock(o_tx_clock[p])
			);

			always @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					sync_line <= 2'b00;
					sync_sys <= 2'b00;
					ones_run <= 2'b00;
					reset_seen <= 1'b0;
					o_line_tx_sync_pin[p] <= 1'b0;
					o_line_tx_sync_oe_n[p] <= 1'b1;
					o_tx_sync_in[p] <= 1'b0;
					o_system_sync_in[p] <= 1'b0;
					o_bpv_armed[p] <= 1'b0;
					o_bpv_insert[p] <= 1'b0;
					o_estore_align[p] <= 1'b0;
					o_estore_reset[p] <= 1'b0;
					o_estore_slip[p] <= 1'b0;
				end else begin
					sync_line <= {sync_line[0], i_line_tx_sync_pin[p]};
					sync_sys <= {sync_sys[0], i_system_tx_sync_pin[p]};
					o_line_tx_sync_oe_n[p] <= !r_io[`TFC_B_TX_SYNC_DIRECTION];
					o_line_tx_sync_pin[p] <= i_tx_sync_gen[p] ^ r_io[`TFC_B_SINV];
					// an output-mode pin is not read back as a reference
					o_tx_sync_in[p] <= !r_io[`TFC_B_TX_SYNC_DIRECTION] &&
						(sync_line[1] ^ r_io[`TFC_B_SINV]);
					o_system_sync_in[p] <= sync_sys[1] ^ r_io[`TFC_B_SSINV];
					if (i_tx_bit_valid[p]) begin
						if (!i_tx_bit[p]) begin
							ones_run <= 2'b00;
						end else if (ones_run != `TFC_ONES_RUN) begin
							ones_run <= ones_run + 2'd1;
						end
					end
					o_bpv_insert[p] <= bpv_fire;
					// a new arm in the same cycle as the insertion wins
					if (bpv_rise) begin
						o_bpv_armed[p] <= 1'b1;
					end else if (bpv_fire) begin
						o_bpv_armed[p] <= 1'b0;
					end
					o_estore_align[p] <= algn_rise && r_es[`TFC_B_ESE] && (sep < half);
					o_estore_reset[p] <= esr_rise && r_es[`TFC_B_ESE];
					// separation is judged in the same cycle as the o_estore_reset pulse, one cycle after the write
					reset_seen <= esr_rise && r_es[`TFC_B_ESE];
					o_estore_slip[p] <= r_es[`TFC_B_ESE] && (sep <= zone) &&
						(i_rate_convert[p] || reset_seen);
				end
			end

			always @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					o_e1_mode[p] <= 1'b0;
					o_rai_send[p] <= 1'b0;
					o_rai_j1[p] <= 1'b0;
					o_d4_framing[p] <= 1'b0;
					o_b7_stuff_all[p] <= 1'b0;
					o_b7_stuff_sel[p] <= 1'b0;
					o_auto_ebit[p] <= 1'b0;
					o_auto_ais[p] <= 1'b0;
					o_auto_rai[p] <= 1'b0;
					o_mf_ref_system[p] <= 1'b0;
					o_loop_code_en[p] <= 1'b0;
					o_crc4_recalc[p] <= 1'b0;
					o_sysclk_fast[p] <= 1'b0;
					o_system_sync_mf[p] <= 1'b0;
					o_tx_sync_mf[p] <= 1'b0;
					o_sync_double_wide[p] <= 1'b0;
					o_rate_56k[p] <= 1'b0;
					o_gapped_clk[p] <= 1'b0;
					o_estore_en[p] <= 1'b0;
					o_estore_min_delay[p] <= 1'b0;
					o_milliwatt_alaw[p] <= 1'b0;
				end else begin
					o_e1_mode[p] <= e1;
					o_rai_send[p] <= r_c1[`TFC_B_RAI_EN];
					o_rai_j1[p] <= !e1 && r_c2[`TFC_B_RAI_TYPE];
					o_d4_framing[p] <= !e1 && r_c3[`TFC_B_TFM];
					o_b7_stuff_all[p] <= !e1 && r_c2[`TFC_B_B7ZS] &&
						r_c1[`TFC_B_GB7];
					o_b7_stuff_sel[p] <= !e1 && r_c2[`TFC_B_B7ZS] &&
						!r_c1[`TFC_B_GB7];
					o_auto_ebit[p] <= e1 && r_c2[`TFC_B_AUTO_EBIT_EN];
					o_auto_ais[p] <= e1 && r_c2[`TFC_B_AUTO_AIS_GEN_EN];
					o_auto_rai[p] <= e1 && r_c2[`TFC_B_ARA];
					o_mf_ref_system[p] <= r_c3[`TFC_B_MULTIFRAME_REF_SEL];
					o_loop_code_en[p] <= !e1 && r_c3[`TFC_B_BIT0];
					o_crc4_recalc[p] <= e1 && r_c3[`TFC_B_BIT0];
					o_sysclk_fast[p] <= r_io[`TFC_B_SCLKM];
					o_system_sync_mf[p] <= r_io[`TFC_B_SYSTEM_SYNC_FRAME_MODE];
					o_tx_sync_mf[p] <= r_io[`TFC_B_TSM];
					// a misprogrammed double-wide bit is ignored rather than mangling sync
					o_sync_double_wide[p] <= !e1 && r_io[`TFC_B_SYNC_DOUBLE_WIDE_EN] &&
						r_io[`TFC_B_TX_SYNC_DIRECTION] && !r_io[`TFC_B_TSM];
					o_rate_56k[p] <= r_es[`TFC_B_FMT];
					o_gapped_clk[p] <= r_es[`TFC_B_GCLK];
					o_estore_en[p] <= r_es[`TFC_B_ESE];
					o_estore_min_delay[p] <= r_es[`TFC_B_ESE] && r_es[`TFC_B_MDM];
					o_milliwatt_alaw[p] <= r_c4[`TFC_B_LAW];
				end
			end
		end
	endgenerate
endmodule // tfc_regs
`default_nettype wire

// ### tb/tb_tfc_regs.sv
// self-checking bench for the transmit control register block
// assumes tfc_regs as top, the line clock model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "tfc_defines.vh"
module tb_tfc_regs;
	localparam NP = 4;
	logic i_clk, i_arst_n, psel, pen, pwr, stop, errflag;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [NP-1:0] tsync, ssync, sgen, bval, bdat, rconv;
	logic [7*NP-1:0] sep;
	logic [31:0] expq[$];
	wire [31:0] prdata;
	wire pready, pslverr, ltx, lrx;
	wire [NP-1:0] use_rx, spin, soe_n, e1, rai, raij1, d4, ebit, ais, arai, loopc, crc4, ins, slip;
	wire [NP-1:0] sclk;
	int n_errors, compares, seed, p, i, c;
	tfc_line_model u_line (.i_stop(stop), .o_tx_clk(ltx), .o_rx_clk(lrx));
	tfc_regs #(.NPORTS(NP), .CHAN_CYCLES(20)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_line_tx_clock_pin({NP{ltx}}), .i_recovered_rx_clock({NP{lrx}}),
		.i_line_tx_sync_pin(tsync), .i_system_tx_sync_pin(ssync), .i_tx_sync_gen(sgen),
		.i_tx_bit_valid(bval), .i_tx_bit(bdat), .i_rate_convert(rconv), .i_estore_sep(sep),
		.o_tx_clock(), .o_use_rx_clock(use_rx), .o_line_tx_sync_pin(spin),
		.o_line_tx_sync_oe_n(soe_n), .o_tx_sync_in(), .o_system_sync_in(), .o_e1_mode(e1),
		.o_rai_send(rai), .o_rai_j1(raij1), .o_d4_framing(d4), .o_b7_stuff_all(),
		.o_b7_stuff_sel(), .o_auto_ebit(ebit), .o_auto_ais(ais), .o_auto_rai(arai),
		.o_mf_ref_system(), .o_loop_code_en(loopc), .o_crc4_recalc(crc4), .o_sysclk_fast(sclk),
		.o_system_sync_mf(), .o_tx_sync_mf(), .o_sync_double_wide(), .o_rate_56k(),
		.o_gapped_clk(), .o_estore_en(), .o_estore_min_delay(), .o_milliwatt_alaw(),
		.o_bpv_armed(), .o_bpv_insert(ins), .o_estore_align(), .o_estore_reset(),
		.o_estore_slip(slip));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	function logic [15:0] adr(input int port, input int idx);
		adr = 16'((idx + 'h200 * port) * 4);
	endfunction
	function logic [7:0] mask(input int k);
		case (k)
			0: mask = `TFC_MASK_MODE;
			3: mask = `TFC_MASK_CTRL3;
			5: mask = `TFC_MASK_ESTORE;
			default: mask = 8'hFF;
		endcase
	endfunction
	// setup cycle, access cycle, then hold until pready is seen high
	task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= {24'h00_0000, d};
		@(posedge i_clk);
		pen <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1) @(posedge i_clk);
		errflag = pslverr;
		psel <= 1'b0; pen <= 1'b0;
	endtask
	task wr(input int port, input int idx, input logic [7:0] d);
		apb(1'b1, adr(port, idx), d);
		repeat (3) @(posedge i_clk);
	endtask
	task rd(input int port, input int idx, input logic [7:0] exp);
		expq.push_back({24'h00_0000, exp});
		apb(1'b0, adr(port, idx), 8'h00);
	endtask
	// drive a run of n valid ones on port 0 and count violation pulses
	task ones(input int n);
		c = 0;
		repeat (n) begin
			@(posedge i_clk);
			bval <= 4'hF; bdat <= 4'(1 | $random(seed));
			if (ins[0] === 1'b1) c++;
		end
		@(posedge i_clk);
		bval <= 4'h0;
		repeat (3) @(posedge i_clk) if (ins[0] === 1'b1) c++;
	endtask
	always @(posedge i_clk) if (psel && pen && pready && !pwr) check(prdata, expq.pop_front());
	initial begin
		#200_000;
		n_errors++;
		give_verdict;
	end
	initial begin
		seed = 2249; n_errors = 0; compares = 0; i_arst_n = 1'b0; stop = 1'b0;
		psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; tsync = 0; ssync = 0; sgen = 0;
		bval = 0; bdat = 0; rconv = 0; sep = {NP{7'd20}};
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		tsync <= 4'($random(seed)); ssync <= 4'($random(seed));
		for (p = 0; p < NP; p += 3) for (i = 0; i < 7; i++) rd(p, `TFC_IDX_MODE + i, 8'h00);
		for (p = 0; p < NP; p += 3) for (i = 0; i < 7; i++) begin
			c = $random(seed);
			wr(p, `TFC_IDX_MODE + i, 8'(c));
			rd(p, `TFC_IDX_MODE + i, 8'(c) & mask(i));
		end
		rd(0, 'h187, 8'h00);
		check(errflag, 1'b1);
		expq.push_back(32'h0000_0000);
		apb(1'b0, adr(0, `TFC_IDX_CTRL3) + 16'h0001, 8'h00);
		check(errflag, 1'b1);
		for (i = 0; i < 7; i++) wr(0, `TFC_IDX_MODE + i, 8'h00);
		wr(0, `TFC_IDX_CTRL2, 8'h04);
		check(rai[0], 1'b0);
		wr(0, `TFC_IDX_CTRL1, 8'h01);
		check({rai[0], raij1[0]}, 2'b11);
		wr(0, `TFC_IDX_CTRL2, 8'h00);
		check({rai[0], raij1[0]}, 2'b10);
		wr(0, `TFC_IDX_CTRL3, 8'h05);
		check({d4[0], loopc[0], crc4[0]}, 3'b110);
		wr(0, `TFC_IDX_MODE, 8'h01);
		wr(0, `TFC_IDX_CTRL2, 8'hE0);
		check({e1[0], d4[0], loopc[0], crc4[0]}, 4'b1001);
		check({ebit[0], ais[0], arai[0]}, 3'b111);
		wr(0, `TFC_IDX_MODE, 8'h00);
		check({ebit[0], ais[0], arai[0]}, 3'b000);
		wr(0, `TFC_IDX_CTRL3, 8'h00);
		wr(0, `TFC_IDX_CTRL3, 8'h02);
		ones(6);
		check(c, 1);
		wr(0, `TFC_IDX_CTRL3, 8'h02);
		ones(6);
		check(c, 0);
		wr(0, `TFC_IDX_CTRL3, 8'h10);
		stop <= 1'b1;
		repeat (60) @(posedge i_clk);
		check(use_rx[0], 1'b1);
		stop <= 1'b0;
		repeat (20) @(posedge i_clk);
		check(use_rx[0], 1'b0);
		wr(0, `TFC_IDX_CTRL3, 8'h30);
		check(use_rx[0], 1'b1);
		wr(0, `TFC_IDX_CTRL3, 8'h20);
		check(use_rx[0], 1'b0);
		rconv <= 4'hF;
		for (i = 0; i < 4; i++) begin
			wr(0, `TFC_IDX_ESTORE, i > 1 ? 8'h11 : 8'h01);
			sep[6:0] <= 7'(i > 1 ? i : 9 + i);
			repeat (4) @(posedge i_clk);
			check(slip[0], i % 2 == 0);
		end
		rconv <= 4'h0;
		repeat (4) @(posedge i_clk);
		check(slip[0], 1'b0);
		wr(0, `TFC_IDX_IO, 8'h04);
		sgen <= 4'hF;
		repeat (4) @(posedge i_clk);
		check({spin[0], soe_n[0]}, 2'b10);
		wr(0, `TFC_IDX_IO, 8'h44);
		check(spin[0], 1'b0);
		wr(0, `TFC_IDX_IO, 8'h00);
		check(soe_n[0], 1'b1);
		wr(0, `TFC_IDX_IO, 8'h10);
		check(sclk[0], 1'b1);
		give_verdict;
	end
endmodule // tb_tfc_regs
`default_nettype wire

// ### tb/tfc_line_model.sv
// line side clock model: transmit clock pin and recovered receive clock
// assumes the bench stops the transmit clock to show a loss of transitions
`timescale 1ns/100ps
`default_nettype none
module tfc_line_model (
	input wire logic i_stop,
	output logic o_tx_clk,
	output logic o_rx_clk
);
	// phases offset from the system clock and from each other on purpose
	initial begin
		o_tx_clk = 1'b0;
		#3;
		forever #40 if (!i_stop) o_tx_clk = ~o_tx_clk;
	end
	initial begin
		o_rx_clk = 1'b0;
		#17;
		forever #40 o_rx_clk = ~o_rx_clk;
	end
endmodule // tfc_line_model
`default_nettype wire

// ### tb/tfc_regs_chk.sv
// assertions on port 0 of the transmit control register block
// assumes it is bound into tfc_regs and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module tfc_regs_chk #(
	parameter NPORTS = 4
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pslverr,
	input wire logic [NPORTS-1:0] o_e1_mode,
	input wire logic [NPORTS-1:0] o_d4_framing,
	input wire logic [NPORTS-1:0] o_loop_code_en,
	input wire logic [NPORTS-1:0] o_auto_ebit,
	input wire logic [NPORTS-1:0] o_crc4_recalc,
	input wire logic [NPORTS-1:0] o_line_tx_sync_oe_n,
	input wire logic [NPORTS-1:0] o_tx_sync_in,
	input wire logic [NPORTS-1:0] o_estore_en,
	input wire logic [NPORTS-1:0] o_estore_min_delay,
	input wire logic [NPORTS-1:0] o_estore_slip,
	input wire logic [NPORTS-1:0] o_bpv_armed,
	input wire logic [NPORTS-1:0] o_bpv_insert,
	input wire logic [NPORTS-1:0] o_mf_ref_system
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_access;
		i_psel && i_penable;
	endsequence
	sequence s_set_multiframe_ref_sel;
		i_pwrite && i_paddr == 16'h060C && i_pwdata[3];
	endsequence
	a_misaligned_err: assert property (s_access ##0 i_paddr[1:0] != 2'b00 |-> o_pslverr)
		else $error("misaligned access without error");
	a_multiframe_ref_sel_write: assert property (s_access ##0 s_set_multiframe_ref_sel |-> ##[1:2] o_mf_ref_system[0])
		else $error("reference select not applied");
	a_bpv_once: assert property (o_bpv_insert[0] |=> !o_bpv_insert[0])
		else $error("violation insert longer than a cycle");
	a_bpv_armed: assert property (o_bpv_insert[0] |-> $past(o_bpv_armed[0]))
		else $error("violation inserted while not armed");
	a_e1_no_t1: assert property (o_e1_mode[0] |-> !o_d4_framing[0] && !o_loop_code_en[0])
		else $error("t1 control active in e1");
	a_t1_no_e1: assert property (!o_e1_mode[0] |-> !(o_auto_ebit[0] || o_crc4_recalc[0]))
		else $error("e1 control active in t1");
	a_sync_out: assert property (!o_line_tx_sync_oe_n[0] && $past(!o_line_tx_sync_oe_n[0])
		|-> !o_tx_sync_in[0])
		else $error("sync input seen while pin drives");
	a_min_delay: assert property (o_estore_min_delay[0] |-> o_estore_en[0])
		else $error("min delay without elastic store");
	a_slip_en: assert property (o_estore_slip[0] |-> o_estore_en[0] || $past(o_estore_en[0]))
		else $error("slip with elastic store bypassed");
endmodule // tfc_regs_chk
bind tfc_regs tfc_regs_chk #(.NPORTS(NPORTS)) u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pslverr(o_pslverr), .o_e1_mode(o_e1_mode),
	.o_d4_framing(o_d4_framing), .o_loop_code_en(o_loop_code_en), .o_auto_ebit(o_auto_ebit),
	.o_crc4_recalc(o_crc4_recalc), .o_line_tx_sync_oe_n(o_line_tx_sync_oe_n),
	.o_tx_sync_in(o_tx_sync_in), .o_estore_en(o_estore_en),
	.o_estore_min_delay(o_estore_min_delay), .o_estore_slip(o_estore_slip),
	.o_bpv_armed(o_bpv_armed), .o_bpv_insert(o_bpv_insert), .o_mf_ref_system(o_mf_ref_system));
`default_nettype wire
